//--- src/tpm_monitor.sv
// Throughput monitor: per-second byte totals for transaction interfaces and DMA engines.
//
// Function
// - Each DMA engine has its own counter of payload bytes delivered to the user side.
// - Count every transmit transaction interface byte, headers included, all transaction types.
// - Count every receive transaction interface byte, headers included, all transaction types.
// - Separately count payload bytes of upstream memory write packets only.
// - Separately count payload bytes of downstream completion-with-data packets only.
// - All readable totals refresh once per second without any software action.
// - Each readable total equals bytes gathered over one full one-second interval.
`timescale 1ns/1ps

module tpm_acc #(
  parameter int unsigned ADD_W = 13
) (
  input  wire logic                         ref_clk_in,
  input  wire logic                         nrst_in,
  input  wire logic                         tick_in,
  input  wire logic [ADD_W-1:0]             add_in,
  output logic      [tpm_pkg::CNT_W-1:0]    total_out
);
  import tpm_pkg::*;

  logic [CNT_W-1:0] acc_r;
  logic [CNT_W-1:0] acc_nxt;

  // Bytes arriving in the boundary cycle belong to the closing interval, so none are lost.
  assign acc_nxt = acc_r + CNT_W'(add_in);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_r <= '0;
    end else if (tick_in) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      total_out <= '0;
    end else if (tick_in) begin
      total_out <= acc_nxt;
    end
  end
endmodule : tpm_acc

// Sizes one interface beat and reads the first header word of a packet.
module tpm_beat_decode (
  input  wire logic                       beat_in,
  input  wire logic                       sof_in,
  input  wire logic                       eof_in,
  input  wire logic                       half_in,
  input  wire logic [tpm_pkg::DATA_W-1:0] data_in,
  output logic      [tpm_pkg::ADD_W-1:0]  beat_bytes_out,
  output logic      [tpm_pkg::ADD_W-1:0]  len_bytes_out,
  output logic      [31:0]                hdr_out,
  output logic                            start_out
);
  import tpm_pkg::*;

  logic [LEN_HI:LEN_LO] len_field;

  // A short last beat carries only the upper data word.
  assign beat_bytes_out = !beat_in ? '0 :
                          (eof_in && half_in) ? BEAT_HALF_BYTES : BEAT_FULL_BYTES;

  // Header fields are only trusted on a start beat; idle data could look like a packet.
  assign start_out = beat_in && sof_in;
  assign hdr_out   = data_in[HDR_LSB +: 32];
  assign len_field = hdr_out[LEN_HI:LEN_LO];

  // Payload is taken from the declared length, so byte enables inside the last word are ignored.
  // A length field of zero stands for the largest packet, not an empty one.
  assign len_bytes_out = (len_field == LEN_ZERO) ? (MAX_LEN_DW << DW_SHIFT) :
                         (ADD_W'(len_field) << DW_SHIFT);
endmodule : tpm_beat_decode

module tpm_monitor #(
  parameter int unsigned INTERVAL_CYCLES = tpm_pkg::INTERVAL_CYC
) (
  input  wire logic                                        ref_clk_in,
  input  wire logic                                        nrst_in,
  input  wire logic                                        tx_beat_in,
  input  wire logic                                        tx_sof_in,
  input  wire logic                                        tx_eof_in,
  input  wire logic                                        tx_half_in,
  input  wire logic [tpm_pkg::DATA_W-1:0]                  tx_data_in,
  input  wire logic                                        rx_beat_in,
  input  wire logic                                        rx_sof_in,
  input  wire logic                                        rx_eof_in,
  input  wire logic                                        rx_half_in,
  input  wire logic [tpm_pkg::DATA_W-1:0]                  rx_data_in,
  input  wire logic [tpm_pkg::NUM_ENG-1:0]                 eng_valid_in,
  input  wire logic [tpm_pkg::NUM_ENG*tpm_pkg::ENG_BYTES_W-1:0] eng_bytes_in,
  output logic      [tpm_pkg::CNT_W-1:0]                   tx_util_out,
  output logic      [tpm_pkg::CNT_W-1:0]                   rx_util_out,
  output logic      [tpm_pkg::CNT_W-1:0]                   tx_payload_out,
  output logic      [tpm_pkg::CNT_W-1:0]                   rx_payload_out,
  output logic      [tpm_pkg::NUM_ENG*tpm_pkg::CNT_W-1:0]  eng_total_out,
  output logic                                             update_out
);
  import tpm_pkg::*;

  localparam logic [CNT_W-1:0] TERM_CNT = CNT_W'(INTERVAL_CYCLES - 1);

  logic [CNT_W-1:0] tmr_r;
  logic             tick;
  logic [ADD_W-1:0] tx_beat_bytes;
  logic [ADD_W-1:0] rx_beat_bytes;
  logic [ADD_W-1:0] tx_pay_bytes;
  logic [ADD_W-1:0] rx_pay_bytes;
  logic [31:0]      tx_hdr;
  logic [31:0]      rx_hdr;
  logic [ADD_W-1:0] tx_len_bytes;
  logic [ADD_W-1:0] rx_len_bytes;
  logic             tx_start;
  logic             rx_start;

  // Free-running interval counter; software has no way to restart it.
  assign tick = (tmr_r == TERM_CNT);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tmr_r <= '0;
    end else if (tick) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      update_out <= 1'b0;
    end else begin
      update_out <= tick;
    end
  end

  tpm_beat_decode u_tx_dec (
    .beat_in        (tx_beat_in),
    .sof_in         (tx_sof_in),
    .eof_in         (tx_eof_in),
    .half_in        (tx_half_in),
    .data_in        (tx_data_in),
    .beat_bytes_out (tx_beat_bytes),
    .len_bytes_out  (tx_len_bytes),
    .hdr_out        (tx_hdr),
    .start_out      (tx_start)
  );

  tpm_beat_decode u_rx_dec (
    .beat_in        (rx_beat_in),
    .sof_in         (rx_sof_in),
    .eof_in         (rx_eof_in),
    .half_in        (rx_half_in),
    .data_in        (rx_data_in),
    .beat_bytes_out (rx_beat_bytes),
    .len_bytes_out  (rx_len_bytes),
    .hdr_out        (rx_hdr),
    .start_out      (rx_start)
  );

  // Memory write: format has data, type is memory. Completion with data: format is FMT_CPLD, type is TYPE_CPL.
  assign tx_pay_bytes = (tx_start && tx_hdr[FMT_HI] &&
                         tx_hdr[TYPE_HI:TYPE_LO] == TYPE_MEM) ? tx_len_bytes : '0;
  assign rx_pay_bytes = (rx_start &&
                         rx_hdr[FMT_HI:FMT_LO] == FMT_CPLD &&
                         rx_hdr[TYPE_HI:TYPE_LO] == TYPE_CPL) ? rx_len_bytes : '0;

  tpm_acc #(.ADD_W(ADD_W)) u_tx_util (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .tick_in    (tick),
    .add_in     (tx_beat_bytes),
    .total_out  (tx_util_out)
  );

  tpm_acc #(.ADD_W(ADD_W)) u_rx_util (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .tick_in    (tick),
    .add_in     (rx_beat_bytes),
    .total_out  (rx_util_out)
  );

  tpm_acc #(.ADD_W(ADD_W)) u_tx_pay (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .tick_in    (tick),
    .add_in     (tx_pay_bytes),
    .total_out  (tx_payload_out)
  );

  tpm_acc #(.ADD_W(ADD_W)) u_rx_pay (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .tick_in    (tick),
    .add_in     (rx_pay_bytes),
    .total_out  (rx_payload_out)
  );

  for (genvar g = 0; g < NUM_ENG; g++) begin : g_eng
    logic [ENG_BYTES_W-1:0] eng_add;

    assign eng_add = eng_valid_in[g] ? eng_bytes_in[g*ENG_BYTES_W +: ENG_BYTES_W] : '0;

    tpm_acc #(.ADD_W(ENG_BYTES_W)) u_eng (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .tick_in    (tick),
      .add_in     (eng_add),
      .total_out  (eng_total_out[g*CNT_W +: CNT_W])
    );
  end
endmodule : tpm_monitor

//--- inc/tpm_pkg.sv
// Constants shared by the throughput monitor: interval timing and transaction header fields.
package tpm_pkg;
  localparam int unsigned CLK_FREQ_HZ   = 20_000_000;
  localparam int unsigned INTERVAL_S    = 1;
  localparam int unsigned INTERVAL_CYC  = INTERVAL_S * CLK_FREQ_HZ;

  localparam int unsigned CNT_W         = 32;
  localparam int unsigned DATA_W        = 64;
  localparam int unsigned NUM_ENG       = 4;
  localparam int unsigned ENG_BYTES_W   = 4;
  localparam int unsigned ADD_W         = 13;

  localparam logic [ADD_W-1:0] BEAT_FULL_BYTES = 13'h0008;
  localparam logic [ADD_W-1:0] BEAT_HALF_BYTES = 13'h0004;
  localparam logic [ADD_W-1:0] MAX_LEN_DW      = 13'h0400;

  // First header word sits in the upper half of the start beat.
  localparam int unsigned HDR_LSB       = 32;
  localparam int unsigned FMT_HI        = 30;
  localparam int unsigned FMT_LO        = 29;
  localparam int unsigned TYPE_HI       = 28;
  localparam int unsigned TYPE_LO       = 24;
  localparam int unsigned LEN_HI        = 9;
  localparam int unsigned LEN_LO        = 0;
  localparam int unsigned DW_SHIFT      = 2;

  localparam logic [1:0]  FMT_CPLD      = 2'h2;
  localparam logic [4:0]  TYPE_MEM      = 5'h00;
  localparam logic [4:0]  TYPE_CPL      = 5'h0a;
  localparam logic [9:0]  LEN_ZERO      = 10'h000;
endpackage : tpm_pkg

//--- tb/tpm_far_model.sv
// Behavioural far end of one transaction interface that sends whole packets.
`timescale 1ns/1ps
module tpm_far_model (
  input  wire logic        clk_in,
  output logic             beat_out,
  output logic             sof_out,
  output logic             eof_out,
  output logic             half_out,
  output logic [63:0]      data_out
);
  initial {beat_out, sof_out, eof_out, half_out} = 4'h0;
  initial data_out = 64'h0000_0000_0000_0000;
  // Idle data is inverted after each packet so that a stale header can never be counted again.
  task automatic send(input logic [1:0] fmt, input logic [4:0] typ, input logic [9:0] len,
                      input int beats, input logic half);
    for (int i = 0; i < beats; i++) begin
      @(posedge clk_in);
      #1;
      {beat_out, sof_out, eof_out} = {1'b1, i == 0, i == beats - 1};
      half_out = half && (i == beats - 1);
      data_out = (i == 0) ? {1'b0, fmt, typ, 14'h0, len, 32'h5a5a_0f0f} : ~data_out;
    end
    @(posedge clk_in);
    #1;
    {beat_out, sof_out, eof_out, half_out} = 4'h0;
    data_out = ~data_out;
  endtask : send
endmodule : tpm_far_model

//--- tb/tpm_monitor_props.sv
// Concurrent checks on the monitor totals and their refresh pulse.
`timescale 1ns/1ps
module tpm_monitor_props
  import tpm_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = INTERVAL_CYC
) (
  input wire logic                     ref_clk_in,
  input wire logic                     nrst_in,
  input wire logic [CNT_W-1:0]         tx_util_out,
  input wire logic [CNT_W-1:0]         rx_util_out,
  input wire logic [CNT_W-1:0]         tx_payload_out,
  input wire logic [CNT_W-1:0]         rx_payload_out,
  input wire logic [NUM_ENG*CNT_W-1:0] eng_total_out,
  input wire logic                     update_out
);
  logic [31:0] gap_r;
  // Edges since the last refresh; a late or early refresh shows up in this count.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap_r <= 32'h0000_0000;
    end else begin
      gap_r <= update_out ? 32'h0000_0001 : gap_r + 32'h0000_0001;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  a_pulse_one_cycle: assert property (update_out |=> !update_out)
    else $error("refresh pulse longer than one cycle");
  a_refresh_period: assert property (update_out |-> gap_r == INTERVAL_CYCLES)
    else $error("refresh period wrong");
  a_refresh_bound: assert property (gap_r <= INTERVAL_CYCLES)
    else $error("refresh missing");
  a_tx_util_hold: assert property (!update_out |-> $stable(tx_util_out))
    else $error("transmit total changed between refreshes");
  a_rx_util_hold: assert property (!update_out |-> $stable(rx_util_out))
    else $error("receive total changed between refreshes");
  a_tx_pay_hold: assert property (!update_out |-> $stable(tx_payload_out))
    else $error("write payload total changed between refreshes");
  a_rx_pay_hold: assert property (!update_out |-> $stable(rx_payload_out))
    else $error("completion payload total changed between refreshes");
  a_eng_hold: assert property (!update_out |-> $stable(eng_total_out))
    else $error("engine total changed between refreshes");
endmodule : tpm_monitor_props

//--- tb/tb.sv
// Self-checking bench for the throughput monitor with a short interval.
`timescale 1ns/1ps
module tb;
  import tpm_pkg::*;
  localparam int unsigned N = 100;
  localparam int EB[4] = '{0, 1, 7, 15};
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic tx_beat_in, tx_sof_in, tx_eof_in, tx_half_in, rx_beat_in, rx_sof_in, rx_eof_in, rx_half_in;
  logic [DATA_W-1:0] tx_data_in, rx_data_in;
  logic [NUM_ENG-1:0] eng_valid_in = 4'h0;
  logic [NUM_ENG*ENG_BYTES_W-1:0] eng_bytes_in = 16'h0000;
  logic [CNT_W-1:0] tx_util_out, rx_util_out, tx_payload_out, rx_payload_out;
  logic [NUM_ENG*CNT_W-1:0] eng_total_out;
  logic update_out;
  int error_cnt = 0;
  int samples_checked = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  tpm_far_model u_tx (.clk_in(ref_clk_in), .beat_out(tx_beat_in), .sof_out(tx_sof_in),
    .eof_out(tx_eof_in), .half_out(tx_half_in), .data_out(tx_data_in));
  tpm_far_model u_rx (.clk_in(ref_clk_in), .beat_out(rx_beat_in), .sof_out(rx_sof_in),
    .eof_out(rx_eof_in), .half_out(rx_half_in), .data_out(rx_data_in));
  tpm_monitor #(.INTERVAL_CYCLES(N)) dut (.ref_clk_in, .nrst_in, .tx_beat_in, .tx_sof_in,
    .tx_eof_in, .tx_half_in, .tx_data_in, .rx_beat_in, .rx_sof_in, .rx_eof_in, .rx_half_in,
    .rx_data_in, .eng_valid_in, .eng_bytes_in, .tx_util_out, .rx_util_out, .tx_payload_out,
    .rx_payload_out, .eng_total_out, .update_out);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // Returns just after the edge that refreshed the totals.
  task automatic wait_upd;
    for (int i = 0; i <= 2 * N; i++) begin
      @(posedge ref_clk_in);
      #1;
      if (update_out === 1'b1) return;
    end
    error_cnt++;
    wrap_up();
  endtask : wait_upd
  task automatic t_tx;
    wait_upd();
    u_tx.send(2'h2, 5'h00, 10'h002, 2, 1'b1);
    u_tx.send(2'h0, 5'h00, 10'h001, 2, 1'b1);
    u_tx.send(2'h3, 5'h00, 10'h000, 3, 1'b0);
    u_tx.send(2'h1, 5'h00, 10'h003, 2, 1'b0);
    wait_upd();
    chk(tx_util_out, 32'h0000_0040);
    chk(tx_payload_out, 32'h0000_1008);
    chk(rx_util_out, 32'h0000_0000);
  endtask : t_tx
  task automatic t_rx;
    u_rx.send(2'h2, 5'h0a, 10'h001, 2, 1'b1);
    u_rx.send(2'h0, 5'h0a, 10'h001, 2, 1'b1);
    u_rx.send(2'h2, 5'h00, 10'h004, 3, 1'b0);
    u_rx.send(2'h2, 5'h0a, 10'h000, 2, 1'b0);
    wait_upd();
    chk(rx_util_out, 32'h0000_0040);
    chk(rx_payload_out, 32'h0000_1004);
    chk(tx_util_out, 32'h0000_0000);
    chk(tx_payload_out, 32'h0000_0000);
  endtask : t_rx
  // Engine traffic runs across two boundaries, including both tick cycles.
  task automatic t_eng;
    eng_valid_in = 4'he;
    eng_bytes_in = 16'hf715;
    for (int k = 0; k < 2; k++) begin
      wait_upd();
      for (int g = 0; g < NUM_ENG; g++) chk(eng_total_out[g*CNT_W+:CNT_W], 32'(N * EB[g]));
    end
    eng_valid_in = 4'h0;
  endtask : t_eng
  initial begin
    repeat (12) @(posedge ref_clk_in);
    #1;
    chk(tx_util_out, 32'h0000_0000);
    nrst_in = 1'b1;
    t_tx();
    t_rx();
    t_eng();
    wrap_up();
  end
endmodule : tb
bind tpm_monitor tpm_monitor_props #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) u_props (.ref_clk_in,
  .nrst_in, .tx_util_out, .rx_util_out, .tx_payload_out, .rx_payload_out, .eng_total_out,
  .update_out);
